// ---- pkg/tpgd_pkg.sv ----
/*
  Types of the three-phase gate drive logic.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package tpgd_pkg;

  // ==========================================================
  // modes and phase drive states
  typedef enum logic {
    TPGD_MODE_SIX = 1'b0,
    TPGD_MODE_THREE = 1'b1
  } tpgd_mode_t;

  typedef enum logic [1:0] {
    TPGD_PH_OFF = 2'b00,
    TPGD_PH_HIGH = 2'b01,
    TPGD_PH_LOW = 2'b10
  } tpgd_phase_t;

  // ==========================================================
  // fault condition inputs
  typedef struct packed {
    logic thermal_shutdown;
    logic shunt_overcurrent;
    logic drain_source_overcurrent;
    logic bootstrap_undervoltage;
    logic gate_supply_undervoltage;
    logic supply_undervoltage;
  } tpgd_fault_t;

endpackage : tpgd_pkg

`default_nettype wire

// ---- pkg/tpgd_regs.svh ----
/*
  Constants of the three-phase gate drive logic: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// Notes on behaviour
// - six-input mode: both commands low keeps both gates low, phase floats.
// - six-input mode: only high command drives high gate; only low drives low.
// - six-input mode: both commands high at once turns both gates of that phase off.
// - in neither mode can the high and low commands turn on both gates of one phase.
// - three-input mode: low command low forces both gates low, phase floats.
// - three-input mode, low command high: high command picks high or low gate.
// - a dead time separates one gate turning off and the other on.
// - dead time adjustable linearly from 100 ns to 2000 ns by setting pin.
// - setting pin open or grounded gives a fixed dead time of 55 ns.
// - command edges pass a short digital delay doing decode and dead time.
// - six fault conditions are monitored as fault events.
// - fault events are reported on the active-low fault output.
// - fault output is open drain, pulls low only, needs outside pull-up.
// - mode comes from a four-level configuration input.
`ifndef TPGD_REGS_SVH
`define TPGD_REGS_SVH

// ==========================================================
// register map
`define TPGD_CTRL_OFS 8'h00
`define TPGD_STATUS_OFS 8'h04
`define TPGD_CONFIG_OFS 8'h08
`define TPGD_GATES_OFS 8'h0c
`define TPGD_CTRL_FORCE_OFF_BIT 0
`define TPGD_CTRL_CLEAR_BIT 1
`define TPGD_STATUS_DRIVE_BIT 8
`define TPGD_CONFIG_MODE_BIT 0
`define TPGD_CONFIG_DT_LSB 8
`define TPGD_CONFIG_VALID_BIT 16
`define TPGD_GATES_LOW_LSB 4
`define TPGD_CTRL_RESET 1'b0
`define TPGD_RESP_OKAY 2'h0
`define TPGD_RESP_SLVERR 2'h2

// ==========================================================
// timing
`define TPGD_CLK_NS 10
`define TPGD_DT_FIXED_NS 55
`define TPGD_DT_STEP_NS 100
`define TPGD_DT_MAX_NS 2000
`define TPGD_DT_FIXED_CYC \
  ((`TPGD_DT_FIXED_NS + `TPGD_CLK_NS - 1) / `TPGD_CLK_NS)
`define TPGD_DT_STEP_CYC ((`TPGD_DT_STEP_NS + `TPGD_CLK_NS - 1) / `TPGD_CLK_NS)
`define TPGD_DT_MAX_CODE (`TPGD_DT_MAX_NS / `TPGD_DT_STEP_NS)
`define TPGD_START_CYC 2'h3

`endif

// ---- test/testbench.sv ----
/*
  Self-checking bench of the gate drive logic with a controller model.
  Assumes the register map and dead-time constants of the header.
*/
`include "tpgd_regs.svh"
`default_nettype none

module testbench
  import tpgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_in, rst_in, fault_flag_n_out, fault_flag_oe_out, fault_line;
  logic [2:0] want_hs, want_ls, high_side_cmd_in, low_side_cmd_in;
  logic [2:0] high_gate_out, low_gate_out;
  logic [1:0] mode_level_in, axi_bresp_out, axi_rresp_out;
  logic [4:0] deadtime_set_pin_in;
  tpgd_fault_t fault_cond_in;
  logic [7:0] axi_awaddr_in, axi_araddr_in;
  logic [31:0] axi_wdata_in, axi_rdata_out;
  logic [3:0] axi_wstrb_in;
  logic axi_awvalid_in, axi_awready_out, axi_wvalid_in, axi_wready_out;
  logic axi_bvalid_out, axi_bready_in, axi_arvalid_in, axi_arready_out;
  logic axi_rvalid_out, axi_rready_in;
  int err_total, checks;

  tpgd_ctrl_model i_ctrl (
    .sys_clk_in, .rst_in, .want_hs_in(want_hs), .want_ls_in(want_ls),
    .fault_oe_in(fault_flag_oe_out), .high_side_cmd_out(high_side_cmd_in),
    .low_side_cmd_out(low_side_cmd_in), .fault_line_out(fault_line)
  );

  tpgd_gate_logic i_dut (
    .sys_clk_in, .rst_in, .high_side_cmd_in, .low_side_cmd_in,
    .mode_level_in, .deadtime_set_pin_in, .fault_cond_in,
    .high_gate_out, .low_gate_out, .fault_flag_n_out, .fault_flag_oe_out,
    .axi_awaddr_in, .axi_awvalid_in, .axi_awready_out, .axi_wdata_in,
    .axi_wstrb_in, .axi_wvalid_in, .axi_wready_out, .axi_bresp_out,
    .axi_bvalid_out, .axi_bready_in, .axi_araddr_in, .axi_arvalid_in,
    .axi_arready_out, .axi_rdata_out, .axi_rresp_out, .axi_rvalid_out,
    .axi_rready_in
  );

  always #5 sys_clk_in = !sys_clk_in;

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge sys_clk_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'b1;
    axi_wvalid_in <= 1'b1;
    axi_bready_in <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge sys_clk_in);
      if (axi_awready_out) axi_awvalid_in <= 1'b0;
      if (axi_wready_out) axi_wvalid_in <= 1'b0;
      if (axi_bvalid_out) break;
    end
    axi_bready_in <= 1'b0;
    chk("write answered", 32'h1, {31'h0, axi_bvalid_out});
    chk("write resp", {30'h0, r}, {30'h0, axi_bresp_out});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] r);
    @(posedge sys_clk_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'b1;
    axi_rready_in <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge sys_clk_in);
      if (axi_arready_out) axi_arvalid_in <= 1'b0;
      if (axi_rvalid_out) break;
    end
    axi_rready_in <= 1'b0;
    chk("read answered", 32'h1, {31'h0, axi_rvalid_out});
    chk("read data", e, axi_rdata_out);
    chk("read resp", {30'h0, r}, {30'h0, axi_rresp_out});
  endtask : axi_rd

  // settles past sync, decode and the longest dead time
  task automatic set_cmd(input logic l, input logic h);
    @(posedge sys_clk_in);
    want_hs <= {3{h}};
    want_ls <= {3{l}};
    repeat (220) @(posedge sys_clk_in);
  endtask : set_cmd

  // ==========================================================
  // scenarios
  task automatic restart(input logic [1:0] m, input logic [4:0] d);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    mode_level_in <= m;
    deadtime_set_pin_in <= d;
    want_hs <= 3'h0;
    want_ls <= 3'h0;
    repeat (20) @(posedge sys_clk_in);
    chk("reset gates", 32'h0, {26'h0, low_gate_out, high_gate_out});
    rst_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    axi_rd(`TPGD_CONFIG_OFS, {15'h0, 1'b1, 3'h0, d, 7'h0, m[1]},
           `TPGD_RESP_OKAY);
  endtask : restart

  task automatic t_table(input logic three);
    logic h;
    logic l;
    for (int i = 0; i < 4; i++) begin
      set_cmd(i[1], i[0]);
      h = i[0] & (three ? i[1] : !i[1]);
      l = i[1] & !i[0];
      chk("gates", {26'h0, {3{l}}, {3{h}}},
          {26'h0, low_gate_out, high_gate_out});
    end
  endtask : t_table

  task automatic dt_meas(input logic lsh, input logic [31:0] n_exp);
    int n;
    set_cmd(lsh, 1'b1);
    @(posedge sys_clk_in);
    want_hs <= 3'h0;
    want_ls <= 3'h7;
    n = 0;
    while (high_gate_out[0] !== 1'b0 && n < 50) begin
      @(negedge sys_clk_in);
      n++;
    end
    n = 0;
    while (low_gate_out[0] !== 1'b1 && n < 300) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("dead time", n_exp, 32'(n));
  endtask : dt_meas

  task automatic t_fault;
    set_cmd(1'b0, 1'b1);
    axi_rd(`TPGD_GATES_OFS, 32'h7, `TPGD_RESP_OKAY);
    axi_wr(`TPGD_CTRL_OFS, 32'h1, `TPGD_RESP_OKAY);
    axi_rd(`TPGD_CTRL_OFS, 32'h1, `TPGD_RESP_OKAY);
    chk("forced off", 32'h0, {26'h0, low_gate_out, high_gate_out});
    axi_wr(`TPGD_CTRL_OFS, 32'h0, `TPGD_RESP_OKAY);
    axi_wr(8'h10, 32'h0, `TPGD_RESP_SLVERR);
    axi_rd(8'h10, 32'h0, `TPGD_RESP_SLVERR);
    for (int b = 0; b < 6; b++) begin
      @(posedge sys_clk_in);
      fault_cond_in <= tpgd_fault_t'(6'h1 << b);
      repeat (8) @(posedge sys_clk_in);
      chk("fault line", 32'h0, {31'h0, fault_line});
      chk("blocked", 32'h0, {26'h0, low_gate_out, high_gate_out});
      axi_rd(`TPGD_STATUS_OFS, 32'h100 | (32'h1 << b),
             `TPGD_RESP_OKAY);
      fault_cond_in <= '0;
      repeat (6) @(posedge sys_clk_in);
      axi_wr(`TPGD_CTRL_OFS, 32'h2, `TPGD_RESP_OKAY);
      repeat (6) @(posedge sys_clk_in);
      chk("fault released", 32'h1, {31'h0, fault_line});
    end
  endtask : t_fault

  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_clk_in = 1'b0;
    rst_in = 1'b1;
    want_hs = 3'h0;
    want_ls = 3'h0;
    mode_level_in = 2'h0;
    deadtime_set_pin_in = 5'h0;
    fault_cond_in = '0;
    axi_awaddr_in = 8'h0;
    axi_araddr_in = 8'h0;
    axi_wdata_in = 32'h0;
    axi_wstrb_in = 4'hf;
    {axi_awvalid_in, axi_wvalid_in, axi_bready_in} = 3'h0;
    {axi_arvalid_in, axi_rready_in} = 2'h0;
    restart(2'h0, 5'h1);
    t_table(1'b0);
    dt_meas(1'b0, `TPGD_DT_STEP_CYC);
    t_fault;
    restart(2'h1, 5'h14);
    dt_meas(1'b0, `TPGD_DT_STEP_CYC * 20);
    restart(2'h2, 5'h0);
    t_table(1'b1);
    dt_meas(1'b1, `TPGD_DT_FIXED_CYC);
    print_verdict();
  end

  initial begin
    #400us;
    err_total++;
    print_verdict();
  end
endmodule : testbench

`default_nettype wire

// ---- test/tpgd_checker.sv ----
/*
  Port checks of the gate drive logic, bound to its top module.
  Assumes mode and dead-time pins only change while reset is held.
*/
`default_nettype none

module tpgd_checker
  import tpgd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // command, configuration and fault inputs
  input wire logic [2:0] high_side_cmd_in,
  input wire logic [2:0] low_side_cmd_in,
  input wire logic [1:0] mode_level_in,
  input wire tpgd_fault_t fault_cond_in,
  // gate and fault outputs
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] low_gate_out,
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  logic six;
  assign six = !mode_level_in[1];

  logic any_fault;
  assign any_fault = |fault_cond_in;

  // ==========================================================
  // reset, decode and dead time
  AST_RESET_QUIET: assert property (
    $fell(rst_in) |-> !fault_flag_oe_out &&
    (high_gate_out | low_gate_out) == 3'h0)
    else $error("output active at reset release");
  AST_SIX_EQUAL_OFF: assert property (
    (six && high_side_cmd_in[0] == low_side_cmd_in[0]) [*4]
    |-> !high_gate_out[0] && !low_gate_out[0])
    else $error("six-input equal commands left a gate on");
  AST_SIX_HIGH_ONLY: assert property (
    (six && high_side_cmd_in[0] && !low_side_cmd_in[0]) [*4]
    |-> !low_gate_out[0])
    else $error("low gate on with only high command");
  AST_THREE_FLOAT: assert property (
    (!six && !low_side_cmd_in[0]) [*4]
    |-> !high_gate_out[0] && !low_gate_out[0])
    else $error("three-input float left a gate on");
  AST_NO_OVERLAP: assert property (
    (high_gate_out & low_gate_out) == 3'h0)
    else $error("both gates of a phase on");
  AST_DEAD_LOW_HIGH: assert property (
    $fell(low_gate_out[0]) |-> !high_gate_out[0] [*6])
    else $error("high gate on inside dead time");
  AST_DEAD_HIGH_LOW: assert property (
    $fell(high_gate_out[1]) |-> !low_gate_out[1] [*6])
    else $error("low gate on inside dead time");

  // ==========================================================
  // fault line
  AST_OPEN_DRAIN: assert property (
    fault_flag_n_out == 1'b0)
    else $error("fault pin drives high");
  AST_FAULT_REPORT: assert property (
    (|fault_cond_in) [*3] |=> fault_flag_oe_out)
    else $error("fault not reported");
  AST_FAULT_BLOCK: assert property (
    fault_flag_oe_out [*2] |-> (high_gate_out | low_gate_out) == 3'h0)
    else $error("gate on during fault");
  AST_FAULT_CAUSE: assert property (
    $rose(fault_flag_oe_out) |-> $past(any_fault, 3))
    else $error("fault line pulled without a fault condition");
endmodule : tpgd_checker

bind tpgd_gate_logic tpgd_checker i_chk (
  .sys_clk_in, .rst_in, .high_side_cmd_in, .low_side_cmd_in,
  .mode_level_in, .fault_cond_in, .high_gate_out, .low_gate_out,
  .fault_flag_n_out, .fault_flag_oe_out
);

`default_nettype wire

// ---- test/tpgd_ctrl_model.sv ----
/*
  Motor controller model: drives the command pins and pulls up
  the fault line. Assumes the bench sets the wanted levels.
*/
`default_nettype none

module tpgd_ctrl_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // wanted levels and fault sink
  input wire logic [2:0] want_hs_in,
  input wire logic [2:0] want_ls_in,
  input wire logic fault_oe_in,
  // pins
  output logic [2:0] high_side_cmd_out,
  output logic [2:0] low_side_cmd_out,
  output logic fault_line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // the pull-up lifts the line whenever nobody sinks it
  assign fault_line_out = fault_oe_in ? 1'b0 : 1'b1;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_side_cmd_out <= 3'h0;
      low_side_cmd_out <= 3'h0;
    end else begin
      high_side_cmd_out <= want_hs_in;
      low_side_cmd_out <= want_ls_in;
    end
  end
endmodule : tpgd_ctrl_model

`default_nettype wire

// ---- verilog/tpgd_gate_logic.sv ----
/*
  Input decode, shoot-through block, dead-time insertion and fault
  reporting of a three-phase half-bridge gate driver, with an AXI4-Lite
  register slave.
  Assumes command, configuration and fault inputs are asynchronous
  levels from pins or analog comparators; the fault wire has an
  external pull-up.
*/
`include "tpgd_regs.svh"
`default_nettype none

module tpgd_gate_logic
  import tpgd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // motor controller commands, one bit per phase
  input wire logic [2:0] high_side_cmd_in,
  input wire logic [2:0] low_side_cmd_in,
  // configuration pins as digitised levels
  input wire logic [1:0] mode_level_in,
  input wire logic [4:0] deadtime_set_pin_in,
  // fault conditions from the monitors
  input wire tpgd_fault_t fault_cond_in,
  // gate enables
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out,
  // open-drain fault line
  output logic fault_flag_n_out,
  output logic fault_flag_oe_out,
  // axi4-lite write address and data
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  // axi4-lite write response
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0] hs_m;
    logic [2:0] hs_s;
    logic [2:0] ls_m;
    logic [2:0] ls_s;
    tpgd_fault_t flt_m;
    tpgd_fault_t flt_s;
    logic [1:0] mode_m;
    logic [1:0] mode_s;
    logic [4:0] dtc_m;
    logic [4:0] dtc_s;
    logic [1:0] start_cnt;
    logic cfg_valid;
    tpgd_mode_t mode;
    logic [4:0] dt_code;
    logic [7:0] dt_cycles;
    tpgd_phase_t [2:0] ph;
    logic [2:0][7:0] dt_cnt;
    logic [2:0] hi_gate;
    logic [2:0] lo_gate;
    tpgd_fault_t flt_lat;
    logic flt_drive;
    logic force_off;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tpgd_state_t;

  tpgd_state_t state_r;
  tpgd_state_t state_nxt;

  // ==========================================================
  // dead time in cycles from the setting code
  function automatic logic [7:0] tpgd_dt_cycles(input logic [4:0] code);
    logic [4:0] c;
    c = code;
    if (code > 5'(`TPGD_DT_MAX_CODE)) begin
      c = 5'(`TPGD_DT_MAX_CODE);
    end
    if (c == 5'h00) begin
      tpgd_dt_cycles = 8'(`TPGD_DT_FIXED_CYC);
    end else begin
      tpgd_dt_cycles = 8'(c * `TPGD_DT_STEP_CYC);
    end
  endfunction : tpgd_dt_cycles

  // ==========================================================
  // command decode for one phase
  function automatic tpgd_phase_t tpgd_decode(input tpgd_mode_t mode,
                                              input logic hs,
                                              input logic ls);
    tpgd_phase_t w;
    w = TPGD_PH_OFF;
    if (mode == TPGD_MODE_SIX) begin
      case ({ls, hs})
        2'b01: w = TPGD_PH_HIGH;
        2'b10: w = TPGD_PH_LOW;
        2'b11: w = TPGD_PH_OFF;
        default: w = TPGD_PH_OFF;
      endcase
    end else begin
      if (!ls) begin
        w = TPGD_PH_OFF;
      end else if (hs) begin
        w = TPGD_PH_HIGH;
      end else begin
        w = TPGD_PH_LOW;
      end
    end
    tpgd_decode = w;
  endfunction : tpgd_decode

  // ==========================================================
  // register read mux
  function automatic logic [32:0] tpgd_read(input logic [7:0] a,
                                            input tpgd_state_t st);
    logic [31:0] d;
    logic err;
    d = 32'h0000_0000;
    err = 1'b0;
    case (a)
      `TPGD_CTRL_OFS: begin
        d[`TPGD_CTRL_FORCE_OFF_BIT] = st.force_off;
      end
      `TPGD_STATUS_OFS: begin
        d[5:0] = st.flt_lat;
        d[`TPGD_STATUS_DRIVE_BIT] = st.flt_drive;
      end
      `TPGD_CONFIG_OFS: begin
        d[`TPGD_CONFIG_MODE_BIT] = st.mode;
        d[`TPGD_CONFIG_DT_LSB +: 5] = st.dt_code;
        d[`TPGD_CONFIG_VALID_BIT] = st.cfg_valid;
      end
      `TPGD_GATES_OFS: begin
        d[2:0] = st.hi_gate;
        d[`TPGD_GATES_LOW_LSB +: 3] = st.lo_gate;
      end
      default: begin
        err = 1'b1;
      end
    endcase
    tpgd_read = {err, d};
  endfunction : tpgd_read

  // ==========================================================
  // next state
  always_comb begin
    tpgd_phase_t want;
    logic gate_block;
    logic clear_req;
    logic [32:0] rd;
    want = TPGD_PH_OFF;
    gate_block = 1'b0;
    clear_req = 1'b0;
    rd = 33'h0_0000_0000;
    state_nxt = state_r;

    // two-flop synchronisers; pin edges reach the gates two to three
    // cycles late, which is the digital delay stage
    state_nxt.hs_m = high_side_cmd_in;
    state_nxt.hs_s = state_r.hs_m;
    state_nxt.ls_m = low_side_cmd_in;
    state_nxt.ls_s = state_r.ls_m;
    state_nxt.flt_m = fault_cond_in;
    state_nxt.flt_s = state_r.flt_m;
    state_nxt.mode_m = mode_level_in;
    state_nxt.mode_s = state_r.mode_m;
    state_nxt.dtc_m = deadtime_set_pin_in;
    state_nxt.dtc_s = state_r.dtc_m;

    // configuration is caught once, after the synchronisers have filled
    if (!state_r.cfg_valid) begin
      if (state_r.start_cnt == `TPGD_START_CYC) begin
        state_nxt.cfg_valid = 1'b1;
        state_nxt.mode = state_r.mode_s[1] ? TPGD_MODE_THREE
                                           : TPGD_MODE_SIX;
        state_nxt.dt_code = state_r.dtc_s;
        state_nxt.dt_cycles = tpgd_dt_cycles(state_r.dtc_s);
      end else begin
        state_nxt.start_cnt = state_r.start_cnt + 2'h1;
      end
    end

    // write channel
    if (state_r.bvalid && axi_bready_in) begin
      state_nxt.bvalid = 1'b0;
    end
    if (axi_awvalid_in && state_r.awready) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && state_r.wready) begin
      state_nxt.w_held = 1'b1;
      state_nxt.wdata = axi_wdata_in;
      state_nxt.wstrb = axi_wstrb_in;
    end
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = `TPGD_RESP_OKAY;
      case (state_r.awaddr)
        `TPGD_CTRL_OFS: begin
          if (state_r.wstrb[0]) begin
            state_nxt.force_off = state_r.wdata[`TPGD_CTRL_FORCE_OFF_BIT];
            clear_req = state_r.wdata[`TPGD_CTRL_CLEAR_BIT];
          end
        end
        `TPGD_STATUS_OFS, `TPGD_CONFIG_OFS, `TPGD_GATES_OFS: begin
          state_nxt.bresp = `TPGD_RESP_OKAY;
        end
        default: begin
          state_nxt.bresp = `TPGD_RESP_SLVERR;
        end
      endcase
    end
    state_nxt.awready = !state_nxt.aw_held && !state_nxt.bvalid;
    state_nxt.wready = !state_nxt.w_held && !state_nxt.bvalid;

    // read channel
    if (state_r.rvalid && axi_rready_in) begin
      state_nxt.rvalid = 1'b0;
    end
    if (axi_arvalid_in && state_r.arready) begin
      rd = tpgd_read(axi_araddr_in, state_r);
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata = rd[31:0];
      state_nxt.rresp = rd[32] ? `TPGD_RESP_SLVERR : `TPGD_RESP_OKAY;
    end
    state_nxt.arready = !state_nxt.rvalid;

    // faults latch; a new event beats a clear in the same cycle
    state_nxt.flt_lat = state_r.flt_s |
                        (clear_req ? 6'h00 : state_r.flt_lat);
    // supply undervoltage holds the line only while present
    gate_block = (|state_r.flt_lat[5:1]) ||
                 state_r.flt_s.supply_undervoltage;
    // only the second synchroniser stage may feed logic
    state_nxt.flt_drive = (|state_nxt.flt_lat[5:1]) ||
                          state_r.flt_s.supply_undervoltage;

    // per-phase drive with dead time
    for (int p = 0; p < 3; p++) begin
      want = tpgd_decode(state_r.mode, state_r.hs_s[p], state_r.ls_s[p]);
      if (!state_r.cfg_valid || gate_block || state_r.force_off) begin
        want = TPGD_PH_OFF;
      end
      if (state_r.ph[p] != TPGD_PH_OFF && want != state_r.ph[p]) begin
        // leaving a driven state: gate off now, then wait out dead time
        state_nxt.ph[p] = TPGD_PH_OFF;
        state_nxt.dt_cnt[p] = state_r.dt_cycles - 8'h01;
      end else if (state_r.ph[p] == TPGD_PH_OFF) begin
        if (state_r.dt_cnt[p] != 8'h00) begin
          state_nxt.dt_cnt[p] = state_r.dt_cnt[p] - 8'h01;
        end else if (want != TPGD_PH_OFF) begin
          state_nxt.ph[p] = want;
        end
      end
      state_nxt.hi_gate[p] = (state_nxt.ph[p] == TPGD_PH_HIGH);
      state_nxt.lo_gate[p] = (state_nxt.ph[p] == TPGD_PH_LOW);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r.hs_m <= 3'h0;
      state_r.hs_s <= 3'h0;
      state_r.ls_m <= 3'h0;
      state_r.ls_s <= 3'h0;
      state_r.flt_m <= 6'h00;
      state_r.flt_s <= 6'h00;
      state_r.mode_m <= 2'h0;
      state_r.mode_s <= 2'h0;
      state_r.dtc_m <= 5'h00;
      state_r.dtc_s <= 5'h00;
      state_r.start_cnt <= 2'h0;
      state_r.cfg_valid <= 1'b0;
      state_r.mode <= TPGD_MODE_SIX;
      state_r.dt_code <= 5'h00;
      state_r.dt_cycles <= 8'(`TPGD_DT_FIXED_CYC);
      state_r.ph <= '{TPGD_PH_OFF, TPGD_PH_OFF, TPGD_PH_OFF};
      state_r.dt_cnt <= 24'h00_0000;
      state_r.hi_gate <= 3'h0;
      state_r.lo_gate <= 3'h0;
      state_r.flt_lat <= 6'h00;
      state_r.flt_drive <= 1'b0;
      state_r.force_off <= `TPGD_CTRL_RESET;
      state_r.aw_held <= 1'b0;
      state_r.w_held <= 1'b0;
      state_r.awaddr <= 8'h00;
      state_r.wdata <= 32'h0000_0000;
      state_r.wstrb <= 4'h0;
      state_r.awready <= 1'b0;
      state_r.wready <= 1'b0;
      state_r.bvalid <= 1'b0;
      state_r.bresp <= 2'h0;
      state_r.arready <= 1'b0;
      state_r.rvalid <= 1'b0;
      state_r.rresp <= 2'h0;
      state_r.rdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign high_gate_out = state_r.hi_gate;
  assign low_gate_out = state_r.lo_gate;
  // the pin only ever pulls low; high comes from the outside pull-up
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_oe_out = state_r.flt_drive;
  assign axi_awready_out = state_r.awready;
  assign axi_wready_out = state_r.wready;
  assign axi_bresp_out = state_r.bresp;
  assign axi_bvalid_out = state_r.bvalid;
  assign axi_arready_out = state_r.arready;
  assign axi_rdata_out = state_r.rdata;
  assign axi_rresp_out = state_r.rresp;
  assign axi_rvalid_out = state_r.rvalid;

endmodule : tpgd_gate_logic

`default_nettype wire
